// [verilog/alarm_event_supervisor_regs.vh]
// Functional notes
// - event action None disables that event entirely
// - signal and warning actions behave the same on this unit
// - signal or warning events blink the error lamp, status not readable
// - alarm action events light lamp steadily, switch input off, record status
// - device alarms switch input off, show on lamp and alarm pins, store status
// - alarms stay latched until acknowledged before normal operation resumes
// - one button press clears all alarms except parallel link loss, next press may switch input on
// - overvoltage protection trips when voltage reaches its threshold
// - overcurrent protection trips when current reaches its threshold
// - overpower protection trips when power reaches its threshold
// - supply failure raises alarm, input off, stored setting picks state after
// - after supply failure clears, a wait is enforced before input on; the restore after cooling is not held off by it
// - overtemperature raises alarm, input off, stored setting picks state after
// - parallel link loss alarm cleared only by reinitialising the parallel system
// - sharing bus attenuation raises a sharing bus failure alarm
// - after reset every event action is None
// - events watched only while input on, device alarms always
// - each event has its own threshold register and a 2-bit field in the shared action register
// - undervoltage event triggers below its threshold
// - overvoltage event triggers above its threshold
// - current events trigger below under threshold or above over threshold
// - overpower event triggers above its threshold
`ifndef ALARM_EVENT_SUPERVISOR_REGS_VH
`define ALARM_EVENT_SUPERVISOR_REGS_VH

`define OFS_CTRL        8'h00
`define OFS_STATUS      8'h04
`define OFS_OVP_THR     8'h08
`define OFS_OCP_THR     8'h0C
`define OFS_OPP_THR     8'h10
`define OFS_EV_ACTION   8'h14
`define OFS_UVD_THR     8'h18
`define OFS_OVD_THR     8'h1C
`define OFS_UCD_THR     8'h20
`define OFS_OCD_THR     8'h24
`define OFS_OPD_THR     8'h28
`define OFS_ALARM_LATCH 8'h2C

// control register bits
`define CTRL_ON_REQ     0
`define CTRL_OFF_REQ    1
`define CTRL_ACK        2
`define CTRL_PF_RESTORE 3
`define CTRL_OT_RESTORE 4
`define CTRL_PAR_REINIT 5

// event action codes
`define ACT_NONE        2'h0
`define ACT_SIGNAL      2'h1
`define ACT_WARNING     2'h2
`define ACT_ALARM       2'h3

// alarm latch bit positions
`define AL_OVP          0
`define AL_OCP          1
`define AL_OPP          2
`define AL_PF           3
`define AL_OT           4
`define AL_PAR          5
`define AL_SHARE        6
`define AL_EVENT        7
`define AL_COUNT        8

`define THR_RESET       16'hFFFF
`define PF_WAIT_MS      5000
`define BLINK_MS        250
`define CLK_KHZ         100000

`endif

// [verilog/alarm_event_supervisor.v]
`timescale 1ns/1ps
`default_nettype none
`include "alarm_event_supervisor_regs.vh"

module alarm_event_supervisor #(
   parameter integer MW          = 16,
   parameter integer PF_WAIT_CYC = `PF_WAIT_MS * `CLK_KHZ,
   parameter integer BLINK_CYC   = `BLINK_MS * `CLK_KHZ
) (
   // clock and reset
   input  wire          sys_clk,
   input  wire          sys_rst,
   // ahb-lite slave
   input  wire          hsel,
   input  wire [31:0]   haddr,
   input  wire [1:0]    htrans,
   input  wire          hwrite,
   input  wire [2:0]    hsize,
   input  wire [31:0]   hwdata,
   input  wire          hready,
   output wire [31:0]   hrdata,
   output wire          hreadyout,
   output wire          hresp,
   // measurements, same clock domain
   input  wire [MW-1:0] meas_voltage,
   input  wire [MW-1:0] meas_current,
   input  wire [MW-1:0] meas_power,
   // hardware fault pins, asynchronous
   input  wire          supply_fail_in,
   input  wire          overtemp_in,
   input  wire          par_link_lost_in,
   input  wire          share_bus_fail_in,
   // front panel button, asynchronous, active high
   input  wire          button_in,
   // outputs
   output reg           dc_input_on,
   output reg           error_led,
   output reg           alarm_out
);

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers: three stages, change accepted when 2nd and 3rd agree

   reg  [4:0] sync1_q;
   reg  [4:0] sync2_q;
   reg  [4:0] sync3_q;
   reg  [4:0] pins_q;
   wire [4:0] pins_raw = {button_in, share_bus_fail_in, par_link_lost_in,
                          overtemp_in, supply_fail_in};

   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         sync1_q <= 5'h00;
         sync2_q <= 5'h00;
         sync3_q <= 5'h00;
         pins_q  <= 5'h00;
      end else begin
         sync1_q <= pins_raw;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
         // hold while the stages disagree, so one stray sample is ignored
         pins_q  <= (sync2_q & sync3_q) | (pins_q & (sync2_q | sync3_q));
      end
   end

   wire pf_lvl    = pins_q[0];
   wire ot_lvl    = pins_q[1];
   wire par_lvl   = pins_q[2];
   wire share_lvl = pins_q[3];
   wire btn_lvl   = pins_q[4];
   reg  btn_prev_q;
   wire btn_press = btn_lvl & ~btn_prev_q;

   ////////////////////////////////////////////////////////////////////////
   // registers

   reg [MW-1:0] ovp_thr_q, ocp_thr_q, opp_thr_q;
   reg [MW-1:0] uvd_thr_q, ovd_thr_q, ucd_thr_q, ocd_thr_q, opd_thr_q;
   reg [9:0]    ev_action_q;
   reg          pf_restore_q;
   reg          ot_restore_q;
   reg [`AL_COUNT-1:0] alarm_q;

   function [MW-1:0] thr_init;
      input dummy;
      begin
         thr_init = {MW{1'b1}};
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // ahb-lite slave, zero wait states

   reg        ph_wr_q;
   reg [7:0]  ph_addr_q;
   reg [31:0] rdata_q;
   wire       take = hsel & hready & htrans[1];

   // read data is captured in the address phase and then stands for the
   // whole data phase, so no wait state is ever needed
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = rdata_q;

   wire wr_ctrl = ph_wr_q & (ph_addr_q == `OFS_CTRL);
   wire [31:0] wctl = wr_ctrl ? hwdata : 32'h0000_0000;

   function [MW-1:0] wthr;
      input          hit;
      input [MW-1:0] old;
      input [31:0]   w;
      begin
         wthr = hit ? w[MW-1:0] : old;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // event detection

   function [1:0] act_of;
      input [9:0] a;
      input [2:0] idx;
      begin
         act_of = a[idx*2 +: 2];
      end
   endfunction

   wire [4:0] ev_cond;
   assign ev_cond[0] = meas_voltage < uvd_thr_q;
   assign ev_cond[1] = meas_voltage > ovd_thr_q;
   assign ev_cond[2] = meas_current < ucd_thr_q;
   assign ev_cond[3] = meas_current > ocd_thr_q;
   assign ev_cond[4] = meas_power > opd_thr_q;

   // warnings are not latched: the lamp blinks only while the cause lasts
   reg ev_alarm_hit;
   reg ev_warn_hit;
   integer k;
   always @* begin
      ev_alarm_hit = 1'b0;
      ev_warn_hit  = 1'b0;
      for (k = 0; k < 5; k = k + 1) begin
         // events only with input on; none ignored
         if (dc_input_on && ev_cond[k]) begin
            if (act_of(ev_action_q, k[2:0]) == `ACT_ALARM)
               ev_alarm_hit = 1'b1;
            else if (act_of(ev_action_q, k[2:0]) != `ACT_NONE)
               ev_warn_hit = 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // alarm sources, watched regardless of input state except the event alarm, which needs the input on

   wire [`AL_COUNT-1:0] al_set;
   assign al_set[`AL_OVP]   = meas_voltage >= ovp_thr_q;
   assign al_set[`AL_OCP]   = meas_current >= ocp_thr_q;
   assign al_set[`AL_OPP]   = meas_power >= opp_thr_q;
   assign al_set[`AL_PF]    = pf_lvl;
   assign al_set[`AL_OT]    = ot_lvl;
   assign al_set[`AL_PAR]   = par_lvl;
   assign al_set[`AL_SHARE] = share_lvl;
   assign al_set[`AL_EVENT] = ev_alarm_hit;

   // acknowledge never clears a cause still present: set wins below
   wire ack = btn_press | wctl[`CTRL_ACK];
   // parallel alarm only cleared by reinit
   wire [`AL_COUNT-1:0] clr_mask = {`AL_COUNT{ack}} &
                                   ~({{(`AL_COUNT-1){1'b0}}, 1'b1} << `AL_PAR);
   wire par_clr = wctl[`CTRL_PAR_REINIT];
   wire any_alarm = |alarm_q;

   ////////////////////////////////////////////////////////////////////////
   // supply failure wait and restore after cooling

   reg [31:0] pf_wait_q;
   reg        pf_prev_q;
   reg        ot_prev_q;
   wire       pf_gone = pf_prev_q & ~pf_lvl;
   wire       ot_gone = ot_prev_q & ~ot_lvl;
   reg        was_on_pf_q;
   reg        was_on_ot_q;

   ////////////////////////////////////////////////////////////////////////
   // a press that acknowledged alarms stays marked until the button is
   // released, so that same press can never also toggle the input

   reg  ack_seen_q;
   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ack_seen_q <= 1'b0;
      end else if (btn_press & any_alarm) begin
         ack_seen_q <= 1'b1;
      end else if (!btn_lvl) begin
         ack_seen_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // restore after cooling: kept pending until every latched alarm has
   // been acknowledged, then applied once; an off request cancels it

   reg  ot_restore_pend_q;
   wire ot_restore_go = ot_restore_pend_q & ~any_alarm & ~(|al_set) &
                        ~wctl[`CTRL_OFF_REQ];
   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ot_restore_pend_q <= 1'b0;
      end else if (ot_gone & ot_restore_q & was_on_ot_q) begin
         ot_restore_pend_q <= 1'b1;
      end else if (ot_restore_go | wctl[`CTRL_OFF_REQ]) begin
         ot_restore_pend_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // main sequential logic

   reg [31:0] blink_q;
   reg        blink_ph_q;

   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ph_wr_q      <= 1'b0;
         ph_addr_q    <= 8'h00;
         rdata_q      <= 32'h0000_0000;
         ovp_thr_q    <= {MW{1'b1}};
         ocp_thr_q    <= {MW{1'b1}};
         opp_thr_q    <= {MW{1'b1}};
         uvd_thr_q    <= {MW{1'b0}};
         ovd_thr_q    <= {MW{1'b1}};
         ucd_thr_q    <= {MW{1'b0}};
         ocd_thr_q    <= {MW{1'b1}};
         opd_thr_q    <= {MW{1'b1}};
         ev_action_q  <= 10'h000;
         pf_restore_q <= 1'b0;
         ot_restore_q <= 1'b0;
         alarm_q      <= {`AL_COUNT{1'b0}};
         dc_input_on  <= 1'b0;
         btn_prev_q   <= 1'b0;
         pf_wait_q    <= 32'h0000_0000;
         pf_prev_q    <= 1'b0;
         ot_prev_q    <= 1'b0;
         was_on_pf_q  <= 1'b0;
         was_on_ot_q  <= 1'b0;
         blink_q      <= 32'h0000_0000;
         blink_ph_q   <= 1'b0;
         error_led    <= 1'b0;
         alarm_out    <= 1'b0;
      end else begin
         btn_prev_q <= btn_lvl;
         pf_prev_q  <= pf_lvl;
         ot_prev_q  <= ot_lvl;
         ph_wr_q    <= take & hwrite;
         ph_addr_q  <= take ? haddr[7:0] : ph_addr_q;

         if (take & ~hwrite) begin
            case (haddr[7:0])
               `OFS_CTRL:        rdata_q <= {27'h0000000,
                                   ot_restore_q, pf_restore_q, 3'h0};
               `OFS_STATUS:      rdata_q <= {21'h0, (pf_wait_q != 32'h0),
                                   dc_input_on, any_alarm, alarm_q};
               `OFS_OVP_THR:     rdata_q <= {{(32-MW){1'b0}}, ovp_thr_q};
               `OFS_OCP_THR:     rdata_q <= {{(32-MW){1'b0}}, ocp_thr_q};
               `OFS_OPP_THR:     rdata_q <= {{(32-MW){1'b0}}, opp_thr_q};
               `OFS_EV_ACTION:   rdata_q <= {22'h0, ev_action_q};
               `OFS_UVD_THR:     rdata_q <= {{(32-MW){1'b0}}, uvd_thr_q};
               `OFS_OVD_THR:     rdata_q <= {{(32-MW){1'b0}}, ovd_thr_q};
               `OFS_UCD_THR:     rdata_q <= {{(32-MW){1'b0}}, ucd_thr_q};
               `OFS_OCD_THR:     rdata_q <= {{(32-MW){1'b0}}, ocd_thr_q};
               `OFS_OPD_THR:     rdata_q <= {{(32-MW){1'b0}}, opd_thr_q};
               `OFS_ALARM_LATCH: rdata_q <= {24'h0, alarm_q};
               default:          rdata_q <= 32'h0000_0000;
            endcase
         end

         if (ph_wr_q) begin
            // separate threshold and action per event
            ovp_thr_q <= wthr(ph_addr_q == `OFS_OVP_THR, ovp_thr_q, hwdata);
            ocp_thr_q <= wthr(ph_addr_q == `OFS_OCP_THR, ocp_thr_q, hwdata);
            opp_thr_q <= wthr(ph_addr_q == `OFS_OPP_THR, opp_thr_q, hwdata);
            uvd_thr_q <= wthr(ph_addr_q == `OFS_UVD_THR, uvd_thr_q, hwdata);
            ovd_thr_q <= wthr(ph_addr_q == `OFS_OVD_THR, ovd_thr_q, hwdata);
            ucd_thr_q <= wthr(ph_addr_q == `OFS_UCD_THR, ucd_thr_q, hwdata);
            ocd_thr_q <= wthr(ph_addr_q == `OFS_OCD_THR, ocd_thr_q, hwdata);
            opd_thr_q <= wthr(ph_addr_q == `OFS_OPD_THR, opd_thr_q, hwdata);
            if (ph_addr_q == `OFS_EV_ACTION)
               ev_action_q <= hwdata[9:0];
            if (wr_ctrl) begin
               pf_restore_q <= hwdata[`CTRL_PF_RESTORE];
               ot_restore_q <= hwdata[`CTRL_OT_RESTORE];
            end
         end

         // latch until ack; set beats clear
         alarm_q <= (alarm_q & ~clr_mask &
                     ~({`AL_COUNT{par_clr}} &
                       ({{(`AL_COUNT-1){1'b0}}, 1'b1} << `AL_PAR)))
                    | al_set;

         // wait after supply failure clears
         // a supply that drops again zeroes the count and restarts it later
         if (pf_gone)
            pf_wait_q <= PF_WAIT_CYC;
         else if (pf_lvl)
            pf_wait_q <= 32'h0000_0000;
         else if (pf_wait_q != 32'h0000_0000)
            pf_wait_q <= pf_wait_q - 32'h0000_0001;

         // remember whether the input was on when the fault arrived
         if (pf_lvl & ~pf_prev_q)
            was_on_pf_q <= dc_input_on;
         if (ot_lvl & ~ot_prev_q)
            was_on_ot_q <= dc_input_on;

         // input state: off on any latched alarm
         // a fresh trip forces the input off in the cycle it is latched
         if ((|al_set) || any_alarm) begin
            dc_input_on <= 1'b0;
         end else if (wctl[`CTRL_OFF_REQ]) begin
            dc_input_on <= 1'b0;
         end else if (pf_wait_q == 32'h0000_0000) begin
            // on requests only with no alarm latched
            if (wctl[`CTRL_ON_REQ])
               dc_input_on <= 1'b1;
            else if (btn_press && !ack_seen_q)
               dc_input_on <= ~dc_input_on;
         end

         // restore after supply failure
         // fires as the wait expires, and only with nothing latched or
         // tripping, so a restore can never override a fresh alarm
         if (!any_alarm && !(|al_set) && pf_restore_q && was_on_pf_q &&
             pf_wait_q == 32'h0000_0001)
            dc_input_on <= 1'b1;

         if (ot_restore_go)
            dc_input_on <= 1'b1;

         // blinking timebase
         // free running so all warnings blink in step; costs one counter
         if (blink_q >= BLINK_CYC - 1) begin
            blink_q    <= 32'h0000_0000;
            blink_ph_q <= ~blink_ph_q;
         end else begin
            blink_q <= blink_q + 32'h0000_0001;
         end

         // steady on alarm, blink on warning
         error_led <= any_alarm | (ev_warn_hit & blink_ph_q);
         alarm_out <= any_alarm;
      end
   end

endmodule
`default_nettype wire

// [tb/panel_button.sv]
`timescale 1ns/1ps
`default_nettype none

module panel_button #(
   parameter integer HOLD = 6
) (
   // clock
   input  wire logic sys_clk,
   // one-cycle request from the bench
   input  wire logic press,
   // contact to the block
   output var  logic button_in
);
   int n;

   initial begin
      n = 0;
      button_in = 1'b0;
   end

   // press held past sync
   // held well past the input synchroniser so no press is lost
   always @(posedge sys_clk) begin
      if (press) begin
         n <= HOLD;
      end else if (n > 0) begin
         n <= n - 1;
      end
      button_in <= press || n > 1;
   end
endmodule

`default_nettype wire

// [tb/supervisor_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
`include "alarm_event_supervisor_regs.vh"

module supervisor_monitor #(
   parameter integer MW          = 16,
   parameter integer PF_WAIT_CYC = 20,
   parameter integer BLINK_CYC   = 4
) (
   // clock, reset, bus
   input wire logic          sys_clk,
   input wire logic          sys_rst,
   input wire logic          hsel,
   input wire logic [31:0]   haddr,
   input wire logic [1:0]    htrans,
   input wire logic          hwrite,
   input wire logic [31:0]   hwdata,
   input wire logic          hready,
   // sources
   input wire logic [MW-1:0] meas_voltage,
   input wire logic          supply_fail_in,
   input wire logic          par_link_lost_in,
   input wire logic          button_in,
   // outputs
   input wire logic          dc_input_on,
   input wire logic          error_led,
   input wire logic          alarm_out
);
   logic          wr_q;
   logic [7:0]    wa_q;
   logic [MW-1:0] ovp_q;
   logic [4:0]    ack_q;
   logic [4:0]    on_q;
   wire           ctl_wr = wr_q && wa_q == `OFS_CTRL;
   wire           ack_hit = (ctl_wr && (hwdata[2] || hwdata[5])) || button_in;
   wire           on_hit = (ctl_wr && hwdata[0]) || button_in;

   ////////////////////////////////////////////////////////////////////////
   // shadow of the trip level and age of the last ack or on request
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         wr_q  <= 1'b0;
         wa_q  <= 8'h00;
         ovp_q <= {MW{1'b1}};
         ack_q <= 5'h1F;
         on_q  <= 5'h1F;
      end else begin
         wr_q  <= hsel && hready && htrans[1] && hwrite;
         wa_q  <= haddr[7:0];
         ovp_q <= (wr_q && wa_q == `OFS_OVP_THR) ? hwdata[MW-1:0] : ovp_q;
         ack_q <= ack_hit ? 5'h00 : ack_q + {4'h0, ack_q != 5'h1F};
         on_q  <= on_hit ? 5'h00 : on_q + {4'h0, on_q != 5'h1F};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst);

   AST_OFF_IN_ALARM:
      assert property (alarm_out [*2] |-> !dc_input_on)
      else $error("input on while alarm latched");
   AST_LED_STEADY:
      assert property (alarm_out [*2] |-> error_led)
      else $error("error lamp dark while alarm latched");
   AST_OVP_TRIP:
      assert property ((meas_voltage >= ovp_q) [*2] |-> ##[1:4] alarm_out)
      else $error("no alarm with voltage at trip level");
   AST_CLEAR_NEEDS_ACK:
      assert property ($fell(alarm_out) |-> ack_q < 5'd12)
      else $error("alarm cleared without acknowledge");
   AST_ON_NEEDS_REQ:
      assert property ($rose(dc_input_on) |-> on_q < 5'd30)
      else $error("input switched on without request");
   AST_PF_TRIP:
      assert property (supply_fail_in [*8] |-> alarm_out && !dc_input_on)
      else $error("supply failure not latched");
   AST_PAR_TRIP:
      assert property (par_link_lost_in [*8] |-> alarm_out && !dc_input_on)
      else $error("parallel link loss not latched");
   AST_RESET_QUIET:
      assert property ($past(sys_rst) |-> !dc_input_on && !alarm_out)
      else $error("outputs active after reset");
endmodule

bind alarm_event_supervisor supervisor_monitor #(
   .MW(MW), .PF_WAIT_CYC(PF_WAIT_CYC), .BLINK_CYC(BLINK_CYC)
) u_mon (
   .sys_clk(sys_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
   .meas_voltage(meas_voltage), .supply_fail_in(supply_fail_in),
   .par_link_lost_in(par_link_lost_in), .button_in(button_in),
   .dc_input_on(dc_input_on), .error_led(error_led), .alarm_out(alarm_out)
);

`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "alarm_event_supervisor_regs.vh"

module tb_top;
   localparam int DC = 2;
   localparam int AL = 0;
   logic        sys_clk, sys_rst, hsel, hwrite, press, hresp, hreadyout;
   logic        dc_input_on, error_led, alarm_out, button_in;
   logic [31:0] haddr, hwdata, hrdata, q;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [15:0] meas [3];
   logic [3:0]  hw;
   int          n_mismatch, n_tests;

   alarm_event_supervisor #(.MW(16), .PF_WAIT_CYC(20), .BLINK_CYC(4)) DUT (
      .sys_clk(sys_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .meas_voltage(meas[0]), .meas_current(meas[1]),
      .meas_power(meas[2]), .supply_fail_in(hw[0]), .overtemp_in(hw[1]),
      .par_link_lost_in(hw[2]), .share_bus_fail_in(hw[3]),
      .button_in(button_in), .dc_input_on(dc_input_on),
      .error_led(error_led), .alarm_out(alarm_out));
   panel_button u_btn (.sys_clk(sys_clk), .press(press), .button_in(button_in));

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop();
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   task automatic wait_rdy();
      int n;
      n = 0;
      @(posedge sys_clk);
      while (hreadyout !== 1'b1) begin
         n++;
         if (n > 64) begin
            n_mismatch++;
            report_and_stop();
         end
         @(posedge sys_clk);
      end
   endtask

   // single word transfer; read data lands in q
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h000000, a};
      hwrite <= wr;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      q = hrdata;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(q, e);
   endtask

   // bounded wait for dc_input_on (2) or alarm_out (0)
   task automatic wait_for(input int s, input logic v);
      logic [2:0] o;
      for (int i = 0; i < 64; i++) begin
         o = {dc_input_on, error_led, alarm_out};
         if (o[s] === v) return;
         @(posedge sys_clk);
      end
      n_mismatch++;
      report_and_stop();
   endtask

   task automatic push();
      press <= 1'b1;
      step(1);
      press <= 1'b0;
      step(1);
   endtask

   ////////////////////////////////////////////////////////////////////////
   task automatic s_reset();
      chk({dc_input_on, error_led, alarm_out}, 32'h0);
      chk({hreadyout, hresp}, 32'h2);
      rd_chk(`OFS_EV_ACTION, 32'h0);
      rd_chk(`OFS_STATUS, 32'h0);
   endtask

   // trip exactly at threshold; ack while the cause is still there
   task automatic s_protect();
      for (int i = 0; i < 3; i++) begin
         bus(1'b1, `OFS_OVP_THR + 8'(4 * i), 32'h100);
         bus(1'b1, `OFS_CTRL, 32'h1);
         wait_for(DC, 1'b1);
         meas[i] <= 16'h0100;
         wait_for(AL, 1'b1);
         step(2);
         chk({dc_input_on, error_led}, 32'h1);
         rd_chk(`OFS_STATUS, 32'h100 | (32'h1 << i));
         bus(1'b1, `OFS_CTRL, 32'h5);
         step(8);
         chk({dc_input_on, alarm_out}, 32'h1);
         meas[i] <= 16'h00FF;
         bus(1'b1, `OFS_CTRL, 32'h4);
         wait_for(AL, 1'b0);
         rd_chk(`OFS_STATUS, 32'h0);
      end
   endtask

   task automatic s_hw();
      for (int j = 0; j < 4; j++) begin
         bus(1'b1, `OFS_CTRL, 32'h1);
         wait_for(DC, 1'b1);
         hw[j] <= 1'b1;
         wait_for(AL, 1'b1);
         step(2);
         chk(dc_input_on, 32'h0);
         rd_chk(`OFS_STATUS, 32'h100 | (32'h8 << j));
         hw[j] <= 1'b0;
         step(6);
         bus(1'b1, `OFS_CTRL, 32'h4);
         if (j == 2) begin
            step(8);
            chk(alarm_out, 32'h1);
            bus(1'b1, `OFS_CTRL, 32'h20);
         end
         wait_for(AL, 1'b0);
         if (j == 0) begin
            bus(1'b1, `OFS_CTRL, 32'h1);
            step(4);
            chk(dc_input_on, 32'h0);
            rd_chk(`OFS_STATUS, 32'h400);
            step(24);
            bus(1'b1, `OFS_CTRL, 32'h1);
            wait_for(DC, 1'b1);
         end
      end
   endtask

   task automatic s_events();
      logic [1:0] seen;
      meas[0] <= 16'h0080;
      bus(1'b1, `OFS_UVD_THR, 32'h200);
      // events only count while the input is on
      bus(1'b1, `OFS_CTRL, 32'h1);
      step(12);
      chk({dc_input_on, error_led, alarm_out}, 32'h4);
      bus(1'b1, `OFS_EV_ACTION, 32'hC0);
      step(12);
      chk(alarm_out, 32'h0);
      for (int k = 1; k < 3; k++) begin
         bus(1'b1, `OFS_EV_ACTION, 32'(k));
         seen = 2'h0;
         for (int i = 0; i < 24; i++) begin
            @(posedge sys_clk);
            seen[error_led] = 1'b1;
         end
         chk(seen, 32'h3);
         rd_chk(`OFS_STATUS, 32'h200);
      end
      bus(1'b1, `OFS_EV_ACTION, 32'h3);
      wait_for(AL, 1'b1);
      step(2);
      chk({dc_input_on, error_led}, 32'h1);
      rd_chk(`OFS_STATUS, 32'h180);
      bus(1'b1, `OFS_CTRL, 32'h4);
      wait_for(AL, 1'b0);
      step(12);
      chk({dc_input_on, error_led, alarm_out}, 32'h0);
      bus(1'b1, `OFS_EV_ACTION, 32'h0);
   endtask

   task automatic s_button();
      hw[1] <= 1'b1;
      wait_for(AL, 1'b1);
      push();
      step(12);
      chk(alarm_out, 32'h1);
      hw[1] <= 1'b0;
      step(6);
      push();
      wait_for(AL, 1'b0);
      step(12);
      chk({dc_input_on, error_led}, 32'h0);
      push();
      wait_for(DC, 1'b1);
      step(12);
      push();
      wait_for(DC, 1'b0);
   endtask

   // restore setting chosen; the input returns once the alarm is acked
   task automatic s_restore();
      bus(1'b1, `OFS_CTRL, 32'h11);
      wait_for(DC, 1'b1);
      hw[1] <= 1'b1;
      wait_for(AL, 1'b1);
      hw[1] <= 1'b0;
      step(6);
      chk(dc_input_on, 32'h0);
      bus(1'b1, `OFS_CTRL, 32'h14);
      wait_for(DC, 1'b1);
      rd_chk(`OFS_CTRL, 32'h10);
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      n_mismatch = 0;
      n_tests = 0;
      sys_rst = 1'b1;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      press = 1'b0;
      hw = 4'h0;
      meas = '{default: 16'h0000};
      repeat (6) @(posedge sys_clk);
      sys_rst <= 1'b0;
      step(1);
      s_reset();
      s_protect();
      s_hw();
      s_events();
      s_button();
      s_restore();
      report_and_stop();
   end
endmodule

`default_nettype wire
